// ===== rtl/ldoreg_a_setting.v
// Decided for this implementation: strobed register access.
`timescale 1ns/1ps
`include "ldoreg_map.vh"

module ldoreg_a_setting (
    // clock and reset
    input  wire       MCLK,
    input  wire       ARST_N,
    // register port
    input  wire [7:0] ADDR,
    input  wire [7:0] WDATA,
    input  wire       WR_STB,
    input  wire       RD_STB,
    output reg  [7:0] RDATA,
    // regulator controls
    output reg        REG1_SLEEP_SELECT,
    output reg  [5:0] REG1_VOLTAGE_CODE,
    output reg        REG2_SLEEP_SELECT,
    output reg  [5:0] REG2_VOLTAGE_CODE,
    output reg        REG3_SLEEP_SELECT,
    output reg  [6:0] REG3_VOLTAGE_CODE
);

    // reset image shared by all three registers
    localparam [7:0] reset_value = `LDOREG_RESET_VALUE;

    // stored bytes and their next values
    reg  [7:0] reg1_reg;
    reg  [7:0] reg2_reg;
    reg  [7:0] reg3_reg;
    reg  [7:0] reg1_next;
    reg  [7:0] reg2_next;
    reg  [7:0] reg3_next;
    reg  [7:0] rdata_next;

    // next values of the regulator outputs
    wire       reg1_sleep_next;
    wire [5:0] reg1_code_next;
    wire       reg2_sleep_next;
    wire [5:0] reg2_code_next;
    wire       reg3_sleep_next;
    wire [6:0] reg3_code_next;

    // address decode, write enables, output load flags
    wire       hit_reg1;
    wire       hit_reg2;
    wire       hit_reg3;
    wire       hit_any;
    wire       wr_reg1;
    wire       wr_reg2;
    wire       wr_reg3;
    wire       rd_mapped;
    reg        reg1_load_reg;
    reg        reg2_load_reg;
    reg        reg3_load_reg;

    assign hit_reg1  = (ADDR == `LDOREG_ADDR_REG1);
    assign hit_reg2  = (ADDR == `LDOREG_ADDR_REG2);
    assign hit_reg3  = (ADDR == `LDOREG_ADDR_REG3);
    assign hit_any   = hit_reg1 | hit_reg2 | hit_reg3;
    assign wr_reg1   = WR_STB & hit_reg1;
    assign wr_reg2   = WR_STB & hit_reg2;
    assign wr_reg3   = WR_STB & hit_reg3;
    assign rd_mapped = RD_STB & hit_any;

    // field split of each stored byte, bit 6 of reg1 and reg2 left out
    assign reg1_sleep_next = reg1_reg[`LDOREG_SLEEP_BIT];
    assign reg1_code_next  = reg1_reg[`LDOREG_CODE6_MSB:0];
    assign reg2_sleep_next = reg2_reg[`LDOREG_SLEEP_BIT];
    assign reg2_code_next  = reg2_reg[`LDOREG_CODE6_MSB:0];
    assign reg3_sleep_next = reg3_reg[`LDOREG_SLEEP_BIT];
    assign reg3_code_next  = reg3_reg[`LDOREG_CODE7_MSB:0];

    // reg1 next value
    always @*
    begin
        reg1_next = reg1_reg;
        if (wr_reg1)
        begin
            reg1_next = WDATA;
        end
    end

    // reg2 next value
    always @*
    begin
        reg2_next = reg2_reg;
        if (wr_reg2)
        begin
            reg2_next = WDATA;
        end
    end

    // reg3 next value
    always @*
    begin
        reg3_next = reg3_reg;
        if (wr_reg3)
        begin
            reg3_next = WDATA;
        end
    end

    // reg1 storage
    always @(posedge MCLK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            reg1_reg <= reset_value;
        end
        else
        begin
            reg1_reg <= reg1_next;
        end
    end

    // reg2 storage
    always @(posedge MCLK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            reg2_reg <= reset_value;
        end
        else
        begin
            reg2_reg <= reg2_next;
        end
    end

    // reg3 storage
    always @(posedge MCLK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            reg3_reg <= reset_value;
        end
        else
        begin
            reg3_reg <= reg3_next;
        end
    end

    // reg1 written last cycle, outputs reload
    always @(posedge MCLK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            reg1_load_reg <= 1'b0;
        end
        else
        begin
            reg1_load_reg <= wr_reg1;
        end
    end

    // reg2 written last cycle, outputs reload
    always @(posedge MCLK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            reg2_load_reg <= 1'b0;
        end
        else
        begin
            reg2_load_reg <= wr_reg2;
        end
    end

    // reg3 written last cycle, outputs reload
    always @(posedge MCLK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            reg3_load_reg <= 1'b0;
        end
        else
        begin
            reg3_load_reg <= wr_reg3;
        end
    end

    // read mux
    always @*
    begin
        case (ADDR)
            `LDOREG_ADDR_REG1: rdata_next = reg1_reg;
            `LDOREG_ADDR_REG2: rdata_next = reg2_reg;
            `LDOREG_ADDR_REG3: rdata_next = reg3_reg;
            default:           rdata_next = `LDOREG_UNMAPPED_DATA;
        endcase
    end

    // read data one cycle after strobe, zero otherwise
    always @(posedge MCLK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            RDATA <= 8'h00;
        end
        else if (rd_mapped)
        begin
            RDATA <= rdata_next;
        end
        else if (RD_STB)
        begin
            RDATA <= `LDOREG_UNMAPPED_DATA;
        end
        else
        begin
            RDATA <= 8'h00;
        end
    end

    // reg1 sleep select output
    always @(posedge MCLK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            REG1_SLEEP_SELECT <= reset_value[`LDOREG_SLEEP_BIT];
        end
        else if (reg1_load_reg)
        begin
            REG1_SLEEP_SELECT <= reg1_sleep_next;
        end
    end

    // reg1 voltage code output
    always @(posedge MCLK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            REG1_VOLTAGE_CODE <= reset_value[`LDOREG_CODE6_MSB:0];
        end
        else if (reg1_load_reg)
        begin
            REG1_VOLTAGE_CODE <= reg1_code_next;
        end
    end

    // reg2 sleep select output
    always @(posedge MCLK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            REG2_SLEEP_SELECT <= reset_value[`LDOREG_SLEEP_BIT];
        end
        else if (reg2_load_reg)
        begin
            REG2_SLEEP_SELECT <= reg2_sleep_next;
        end
    end

    // reg2 voltage code output
    always @(posedge MCLK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            REG2_VOLTAGE_CODE <= reset_value[`LDOREG_CODE6_MSB:0];
        end
        else if (reg2_load_reg)
        begin
            REG2_VOLTAGE_CODE <= reg2_code_next;
        end
    end

    // reg3 sleep select output
    always @(posedge MCLK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            REG3_SLEEP_SELECT <= reset_value[`LDOREG_SLEEP_BIT];
        end
        else if (reg3_load_reg)
        begin
            REG3_SLEEP_SELECT <= reg3_sleep_next;
        end
    end

    // reg3 voltage code output
    always @(posedge MCLK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            REG3_VOLTAGE_CODE <= reset_value[`LDOREG_CODE7_MSB:0];
        end
        else if (reg3_load_reg)
        begin
            REG3_VOLTAGE_CODE <= reg3_code_next;
        end
    end

endmodule // ldoreg_a_setting

// ===== rtl/ldoreg_map.vh
`ifndef LDOREG_MAP_VH
`define LDOREG_MAP_VH
`define LDOREG_ADDR_REG1     8'hA9
`define LDOREG_ADDR_REG2     8'hAA
`define LDOREG_ADDR_REG3     8'hAB
`define LDOREG_SLEEP_BIT     7
`define LDOREG_RSVD_BIT      6
`define LDOREG_CODE6_MSB     5
`define LDOREG_CODE7_MSB     6
`define LDOREG_RESET_VALUE   8'h00
`define LDOREG_UNMAPPED_DATA 8'h00
`endif

// ===== test/ldoreg_props.sv
`timescale 1ns/1ps
module ldoreg_props(input wire MCLK,ARST_N,WR_STB,RD_STB,REG1_SLEEP_SELECT,REG2_SLEEP_SELECT,REG3_SLEEP_SELECT,
input wire [7:0] ADDR,WDATA,RDATA,input wire [5:0] REG1_VOLTAGE_CODE,REG2_VOLTAGE_CODE,
input wire [6:0] REG3_VOLTAGE_CODE);
default clocking @(posedge MCLK);endclocking
default disable iff(!ARST_N);
sequence s_write(a);WR_STB&&ADDR==a;endsequence
sequence s_no_write;!WR_STB;endsequence
sequence s_stray_read;RD_STB&&(ADDR<8'hA9||ADDR>8'hAB);endsequence
property p(a,o,m);s_write(a)|->##2 o==($past(WDATA,2)&m);endproperty
chk_reg1_out:assert property(p(8'hA9,{REG1_SLEEP_SELECT,1'b0,REG1_VOLTAGE_CODE},8'hBF))else $error("reg1 outputs wrong");
chk_reg2_out:assert property(p(8'hAA,{REG2_SLEEP_SELECT,1'b0,REG2_VOLTAGE_CODE},8'hBF))else $error("reg2 outputs wrong");
chk_reg3_out:assert property(p(8'hAB,{REG3_SLEEP_SELECT,REG3_VOLTAGE_CODE},8'hFF))else $error("reg3 outputs wrong");
chk_outputs_hold:assert property(s_no_write|->##2 $stable({REG1_SLEEP_SELECT,REG1_VOLTAGE_CODE,REG2_SLEEP_SELECT,
REG2_VOLTAGE_CODE,REG3_SLEEP_SELECT,REG3_VOLTAGE_CODE}))else $error("outputs moved without a write");
chk_rdata_idle:assert property(!RD_STB|=>RDATA==8'h00)else $error("read data not zero outside a read");
chk_stray_read:assert property(s_stray_read|=>RDATA==8'h00)else $error("unmapped read not zero");
endmodule // ldoreg_props

// ===== test/testbench.sv
`timescale 1ns/1ps
module testbench;
reg MCLK=0,ARST_N=0,WR_STB=0,RD_STB=0;
reg [7:0] ADDR=8'h00,WDATA=8'h00,d,a;
wire [7:0] RDATA;
wire s1,s2,s3;
wire [5:0] c1,c2;
wire [6:0] c3;
int errors=0,n_tests=0;
ldoreg_a_setting u_dut(.MCLK(MCLK),.ARST_N(ARST_N),.ADDR(ADDR),.WDATA(WDATA),.WR_STB(WR_STB),.RD_STB(RD_STB),
.RDATA(RDATA),.REG1_SLEEP_SELECT(s1),.REG1_VOLTAGE_CODE(c1),.REG2_SLEEP_SELECT(s2),.REG2_VOLTAGE_CODE(c2),
.REG3_SLEEP_SELECT(s3),.REG3_VOLTAGE_CODE(c3));
initial forever #2.5 MCLK=~MCLK;
initial begin repeat(199)@(posedge MCLK);errors++;report_and_stop;end
task chk(input [7:0] s,e);n_tests++;if(s!==e) begin errors++;$display("BAD %0t %h %h",$time,s,e);end endtask
task wr(input [7:0] a,v);ADDR<=a;WDATA<=v;WR_STB<=1;@(posedge MCLK);WR_STB<=0;endtask
task rd(input [7:0] a,e);ADDR<=a;RD_STB<=1;@(posedge MCLK);RD_STB<=0;#1 chk(RDATA,e);@(posedge MCLK);endtask
task t_regs;for(int i=0;i<6;i++) begin
d=i<3?8'hC5:8'h3A;a=8'hA9+8'(i%3);wr(a,d);
case(i%3)
0: begin rd(a,d);chk({s1,1'b0,c1},d&8'hBF);end
1: begin rd(a,d);chk({s2,1'b0,c2},d&8'hBF);end
default: begin rd(a,d);chk({s3,c3},d);end
endcase end
wr(8'hAC,8'hFF);rd(8'hAC,8'h00);chk({s3,c3},8'h3A);
chk({s1,1'b0,c1},8'h3A);
endtask
initial begin repeat(2)@(posedge MCLK);ARST_N<=1;@(posedge MCLK);t_regs;report_and_stop;end
task report_and_stop;$display("%0d/%0d",errors,n_tests);
if(errors==0&&n_tests>0) $display("ALL CHECKS OK");else $display("CHECKS NOT OK");$finish;endtask
endmodule // testbench
bind ldoreg_a_setting ldoreg_props u_props(.MCLK(MCLK),.ARST_N(ARST_N),.WR_STB(WR_STB),.RD_STB(RD_STB),
.REG1_SLEEP_SELECT(REG1_SLEEP_SELECT),.REG2_SLEEP_SELECT(REG2_SLEEP_SELECT),.REG3_SLEEP_SELECT(REG3_SLEEP_SELECT),
.ADDR(ADDR),.WDATA(WDATA),.RDATA(RDATA),.REG1_VOLTAGE_CODE(REG1_VOLTAGE_CODE),
.REG2_VOLTAGE_CODE(REG2_VOLTAGE_CODE),.REG3_VOLTAGE_CODE(REG3_VOLTAGE_CODE));
